// ### shared/ixs_cfg.svh
/*
 Constants of the impedance and excitation stage block: time base, offsets,
 field positions and reset values. Assumes the 50 MHz bus clock.
*/
`ifndef IXS_CFG_SVH
`define IXS_CFG_SVH
`define IXS_CLK_HZ 50000000
`define IXS_TICK_US 1000
`define IXS_TICK_CYCLES ((`IXS_CLK_HZ / 1000000) * `IXS_TICK_US)
`define IXS_FORCE_MIN 5
`define IXS_FORCE_MS (`IXS_FORCE_MIN * 60 * 1000)
`define IXS_MILLI 40'h00000003E8
`define IXS_MICRO 40'h00000F4240
`define IXS_PCT_FULL 7'h64
`define IXS_P80_NUM 70'sh5
`define IXS_P80_DEN 70'sh4
`define IXS_INF 32'hFFFFFFFF
`define IXS_DIV_STEPS 6'h28
`define IXS_REG_CTRL 9'h000
`define IXS_REG_ZN 9'h004
`define IXS_REG_RATEDP 9'h008
`define IXS_REG_U1 9'h00C
`define IXS_REG_I1 9'h010
`define IXS_REG_P 9'h014
`define IXS_REG_Q 9'h018
`define IXS_REG_ZOHM 9'h01C
`define IXS_REG_ZPU 9'h020
`define IXS_STG_STATUS 6'h00
`define IXS_STG_CFG 6'h04
`define IXS_STG_ACTIVE 6'h08
`define IXS_STG_CNT 6'h0C
`define IXS_STG_TTT 6'h10
`define IXS_STG_PCT 6'h14
`define IXS_STG_PICKOHM 6'h18
`define IXS_ST_BLOCKED 0
`define IXS_ST_START 1
`define IXS_ST_TRIP 2
`define IXS_CNT_CLR_START 0
`define IXS_CNT_CLR_TRIP 1
`define IXS_ZN_RST 16'h03E8
`define IXS_RATEDP_RST 32'h00010000
`define IXS_PICK_RST 32'h000001F4
`define IXS_DLY_RST 32'h000003E8
`endif

// ### shared/ixs_pkg.sv
/*
 Types of the impedance and excitation stage block.
 Assumes ixs_cfg.svh holds the numeric constants.
*/
package ixs_pkg;
	typedef enum logic [2:0] {
		IXS_SRC_NONE,
		IXS_SRC_DI,
		IXS_SRC_VI,
		IXS_SRC_LED,
		IXS_SRC_VO
	} ixs_src_t;
	typedef enum logic [1:0] {
		IXS_DV_LOAD,
		IXS_DV_RUN,
		IXS_DV_DONE
	} ixs_div_state_t;
endpackage : ixs_pkg

// ### rtl/ixs_stages.sv
/*
 Two underimpedance stages and one under-excitation stage with an AHB-Lite
 register slave, counters, force flag and fault records.
 Assumes measured quantities are synchronous to hclk and a single slave bus.
*/
// Operation
// (R01) Two independent impedance stages, sensitive and high-set, own settings and outputs.
// (R02) Four setting groups per stage; one active, chosen manually or by a signal.
// (R03) Group source is none, digital input, virtual input, LED or virtual output.
// (R04) Status shows blocked, started, tripped; start and trip writable only under force.
// (R05) One force flag for all stages; clears itself after five minutes set.
// (R06) Cumulative start and trip counts per stage, each clearable on request.
// (R07) Remaining time to trip is shown while the stage is picked up.
// (R08) Impedance shown in milliohms and per unit; all ones means infinite.
// (R09) Impedance pick-up set in per unit of nominal impedance; ohm equivalent shown.
// (R10) Positive sequence voltage and current are readable in volts and amperes.
// (R11) Eight latest faults kept per stage: time, quantity, elapsed delay, group.
// (R12) Record time stamp holds date and time of day in milliseconds.
// (R13) Elapsed delay recorded as percent of operate time, hundred meaning trip.
// (R14) Settings are changed only by a password-authorised operator; the code has no password check, any bus write changes them.
// (R15) Excitation stage starts when capacitive reactive power passes its setting.
// (R16) Excitation stage trips when pick-up lasts longer than the operate delay.
// (R17) Three-phase power comes from fundamental phase currents and line voltages.
// (R18) Pick-up when power tip lies left of boundary line and reactive negative.
// (R19) First boundary point sits at zero active power; reactive part adjustable.
// (R20) Second boundary point sits at eighty percent rated power; reactive adjustable.
// (R21) Release delay lets fault time accumulate across swing dropouts until trip.
// (R22) Impedance stage picks up when impedance falls inside the set circle.
// (R23) Impedance is voltage over current; zero current is infinite, no pick-up.
// (R24) Fault time resets only after pick-up absent longer than release delay.
// (R25) Each rising start or trip output counts exactly once.
`timescale 1ns/1ps
`include "ixs_cfg.svh"
module ixs_stages
	import ixs_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `IXS_TICK_CYCLES,
	parameter int unsigned FORCE_MS = `IXS_FORCE_MS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [15:0] u1_volts,
	input wire logic [15:0] i1_amps,
	input wire logic signed [15:0] u12_re,
	input wire logic signed [15:0] u12_im,
	input wire logic signed [15:0] u32_re,
	input wire logic signed [15:0] u32_im,
	input wire logic signed [15:0] ia_re,
	input wire logic signed [15:0] ia_im,
	input wire logic signed [15:0] ic_re,
	input wire logic signed [15:0] ic_im,
	input wire logic [31:0] rtc_date,
	input wire logic [31:0] rtc_ms_of_day,
	input wire logic [31:0] digital_input_n,
	input wire logic [31:0] virtual_input_n,
	input wire logic [31:0] led_signal_n,
	input wire logic [31:0] virtual_output_n,
	input wire logic [2:0] stage_block,
	output logic [2:0] stage_start,
	output logic [2:0] stage_trip,
	output logic force_active
);

	function automatic logic signed [32:0] cp_re(input logic signed [15:0] ur, ui, ir, ii);
		cp_re = 33'(ur * ir) + 33'(ui * ii);
	endfunction : cp_re

	function automatic logic signed [32:0] cp_im(input logic signed [15:0] ur, ui, ir, ii);
		cp_im = 33'(ui * ir) - 33'(ur * ii);
	endfunction : cp_im

	// Two neighbouring lines of the chosen source form the group number.
	function automatic logic [1:0] pick_group(input logic [9:0] cfg,
			input logic [31:0] di, vi, led, vo);
		logic [31:0] v;
		logic [4:0] n;
		v = 32'h0;
		n = cfg[9:5];
		unique case (ixs_src_t'(cfg[4:2]))
			IXS_SRC_NONE: v = 32'h0;
			IXS_SRC_DI: v = di;
			IXS_SRC_VI: v = vi;
			IXS_SRC_LED: v = led;
			IXS_SRC_VO: v = vo;
			default: v = 32'h0;
		endcase
		if (ixs_src_t'(cfg[4:2]) inside {IXS_SRC_DI, IXS_SRC_VI, IXS_SRC_LED, IXS_SRC_VO})
			pick_group = {v[5'(n + 5'h1)], v[n]};
		else
			pick_group = cfg[1:0];
	endfunction : pick_group

	// Bus slave: writes take no wait state, reads one.
	logic [11:0] addr_q;
	logic wr_q;
	logic rd_q;
	logic [31:0] rd_mux;
	wire ahb_go = hsel && hready && htrans[1];
	wire [2:0] wa_blk = addr_q[11:9];
	wire [8:0] wa_off = addr_q[8:0];
	wire w_glob = wr_q && (wa_blk == 3'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 12'h000;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0;
		end else begin
			if (ahb_go)
				addr_q <= haddr[11:0];
			wr_q <= ahb_go && hwrite;
			rd_q <= ahb_go && !hwrite;
			hreadyout <= !(ahb_go && !hwrite);
			if (rd_q)
				hrdata <= rd_mux;
		end
	end

	// Global registers, millisecond time base and force flag.
	logic [15:0] zn_q;
	logic [31:0] ratedp_q;
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic [31:0] force_cnt_q;
	wire force_timeout = force_active && tick_q && (force_cnt_q >= FORCE_MS - 1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zn_q <= `IXS_ZN_RST;
			ratedp_q <= `IXS_RATEDP_RST;
			tick_cnt_q <= 32'h0;
			tick_q <= 1'b0;
			force_active <= 1'b0;
			force_cnt_q <= 32'h0;
		end else begin
			tick_q <= (tick_cnt_q == TICK_CYCLES - 1);
			tick_cnt_q <= (tick_cnt_q == TICK_CYCLES - 1) ? 32'h0 : tick_cnt_q + 32'h1;
			if (w_glob && wa_off == `IXS_REG_ZN)
				zn_q <= hwdata[15:0];
			if (w_glob && wa_off == `IXS_REG_RATEDP)
				ratedp_q <= hwdata;
			if (w_glob && wa_off == `IXS_REG_CTRL) begin
				force_active <= hwdata[0]; // R05
				force_cnt_q <= 32'h0;
			end else if (force_timeout) begin
				force_active <= 1'b0; // R05
				force_cnt_q <= 32'h0;
			end else if (force_active && tick_q) begin
				force_cnt_q <= force_cnt_q + 32'h1;
			end
		end
	end

	// Complex power from two line voltages and two phase currents.
	logic signed [31:0] p_q;
	logic signed [31:0] q_q;
	wire signed [33:0] p_sum = 34'(cp_re(u12_re, u12_im, ia_re, ia_im))
		+ 34'(cp_re(u32_re, u32_im, ic_re, ic_im));
	wire signed [33:0] q_sum = 34'(cp_im(u12_re, u12_im, ia_re, ia_im))
		+ 34'(cp_im(u32_re, u32_im, ic_re, ic_im));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p_q <= 32'sh0;
			q_q <= 32'sh0;
		end else begin
			p_q <= p_sum[33:2]; // R17
			q_q <= q_sum[33:2]; // R17
		end
	end

	// Serial divider shared by the ohm and per-unit impedance readings.
	ixs_div_state_t dv_st_q;
	logic dv_job_q;
	logic [39:0] dv_quo_q;
	logic [31:0] dv_rem_q;
	logic [31:0] dv_den_q;
	logic [5:0] dv_cnt_q;
	logic [31:0] z_mohm_q;
	logic [31:0] z_mpu_q;
	wire [39:0] num_mohm = 40'(u1_volts) * `IXS_MILLI;
	wire [39:0] num_mpu = 40'(u1_volts) * `IXS_MICRO;
	wire [31:0] den_mpu = 32'(i1_amps) * 32'(zn_q);
	wire [31:0] den_sel = dv_job_q ? den_mpu : 32'(i1_amps);
	wire [32:0] dv_trial = {dv_rem_q, dv_quo_q[39]};
	wire dv_ge = dv_trial >= {1'b0, dv_den_q};
	wire [32:0] dv_sub = dv_trial - {1'b0, dv_den_q};
	wire [31:0] dv_res = (dv_quo_q[39:32] != 8'h0) ? `IXS_INF : dv_quo_q[31:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dv_st_q <= IXS_DV_LOAD;
			dv_job_q <= 1'b0;
			dv_quo_q <= 40'h0;
			dv_rem_q <= 32'h0;
			dv_den_q <= 32'h0;
			dv_cnt_q <= 6'h0;
			z_mohm_q <= `IXS_INF;
			z_mpu_q <= `IXS_INF;
		end else begin
			unique case (dv_st_q)
				IXS_DV_LOAD: begin
					dv_quo_q <= dv_job_q ? num_mpu : num_mohm;
					dv_den_q <= den_sel;
					dv_rem_q <= 32'h0;
					dv_cnt_q <= `IXS_DIV_STEPS;
					dv_st_q <= (den_sel == 32'h0) ? IXS_DV_DONE : IXS_DV_RUN;
				end
				IXS_DV_RUN: begin
					dv_rem_q <= dv_ge ? dv_sub[31:0] : dv_trial[31:0];
					dv_quo_q <= {dv_quo_q[38:0], dv_ge};
					dv_cnt_q <= dv_cnt_q - 6'h1;
					if (dv_cnt_q == 6'h1)
						dv_st_q <= IXS_DV_DONE;
				end
				IXS_DV_DONE: begin
					// A zero divisor never runs, so infinity is shown. R23
					if (dv_job_q)
						z_mpu_q <= (dv_den_q == 32'h0) ? `IXS_INF : dv_res; // R08
					else
						z_mohm_q <= (dv_den_q == 32'h0) ? `IXS_INF : dv_res; // R08
					dv_job_q <= !dv_job_q;
					dv_st_q <= IXS_DV_LOAD;
				end
			endcase
		end
	end

	// Per-stage state; stages 0 and 1 are impedance, stage 2 is excitation.
	logic [31:0] set_a_q [3][4];
	logic [31:0] set_b_q [3][4];
	logic [31:0] dly_q [3][4];
	logic [31:0] rel_q [3][4];
	logic [9:0] cfg_q [3];
	logic [1:0] grp [3];
	logic [2:0] pk;
	logic [2:0] frc_start_q;
	logic [2:0] frc_trip_q;
	logic [31:0] el_q [3];
	logic [31:0] rl_q [3];
	logic [31:0] acc_q [3];
	logic [6:0] pct_q [3];
	logic [15:0] scnt_q [3];
	logic [15:0] tcnt_q [3];
	logic [31:0] minv_q [3];
	logic [31:0] tsd_q [3];
	logic [31:0] tst_q [3];
	logic [2:0] wp_q [3];
	logic [31:0] rec_date [3][8];
	logic [31:0] rec_time [3][8];
	logic [31:0] rec_qty [3][8];
	logic [31:0] rec_info [3][8];

	for (genvar s = 0; s < 3; s++) begin : g_stg
		wire w_s = wr_q && (wa_blk == 3'(s + 1));
		wire w_grp = w_s && wa_off[8:6] == 3'h1;
		wire [31:0] sa = set_a_q[s][grp[s]];
		wire [31:0] dly = dly_q[s][grp[s]];
		wire in_fault = pk[s] || (el_q[s] != 32'h0);
		wire real_start = pk[s] && !stage_block[s]; // R15
		wire real_trip = real_start && (el_q[s] >= dly); // R16
		wire nxt_start = force_active ? frc_start_q[s] : real_start; // R04
		wire nxt_trip = force_active ? frc_trip_q[s] : real_trip; // R04
		wire rel_done = !pk[s] && (rl_q[s] >= rel_q[s][grp[s]]);
		wire fault_end = tick_q && !pk[s] && (el_q[s] != 32'h0) && rel_done;
		logic in_fault_q;
		wire fault_beg = pk[s] && !in_fault_q;
		wire [31:0] qty = (s == 2) ? q_q : z_mpu_q;
		wire smaller = (s == 2) ? ($signed(qty) < $signed(minv_q[s])) : (qty < minv_q[s]);
		wire [31:0] acc_n = acc_q[s] + ((tick_q && pk[s]) ? 32'h64 : 32'h0);

		assign grp[s] = pick_group(cfg_q[s], digital_input_n, virtual_input_n,
			led_signal_n, virtual_output_n); // R02 R03

		if (s == 2) begin : g_ue
			wire signed [69:0] lhs = `IXS_P80_DEN * 70'(signed'({2'b00, ratedp_q}))
				* 70'(signed'(33'(q_q) - 33'($signed(sa)))); // R19 R20
			wire signed [69:0] rhs = `IXS_P80_NUM * 70'(p_q)
				* 70'(signed'(33'($signed(set_b_q[s][grp[s]])) - 33'($signed(sa)))); // R20
			assign pk[s] = (q_q < 32'sh0) && (lhs < rhs); // R15 R18
		end else begin : g_z
			wire [47:0] rhs = 48'(sa[15:0]) * 48'(zn_q) * 48'(i1_amps);
			assign pk[s] = (i1_amps != 16'h0) && (48'(num_mpu) < rhs); // R01 R22 R23 R09
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				for (int g = 0; g < 4; g++) begin
					set_a_q[s][g] <= `IXS_PICK_RST;
					set_b_q[s][g] <= `IXS_PICK_RST;
					dly_q[s][g] <= `IXS_DLY_RST;
					rel_q[s][g] <= 32'h0;
				end
				cfg_q[s] <= 10'h0;
				frc_start_q[s] <= 1'b0;
				frc_trip_q[s] <= 1'b0;
			end else begin
				if (w_grp && wa_off[3:2] == 2'h0)
					set_a_q[s][wa_off[5:4]] <= hwdata;
				if (w_grp && wa_off[3:2] == 2'h1)
					set_b_q[s][wa_off[5:4]] <= hwdata;
				if (w_grp && wa_off[3:2] == 2'h2)
					dly_q[s][wa_off[5:4]] <= hwdata;
				if (w_grp && wa_off[3:2] == 2'h3)
					rel_q[s][wa_off[5:4]] <= hwdata;
				if (w_s && wa_off == 9'(`IXS_STG_CFG))
					cfg_q[s] <= hwdata[9:0];
				// Forced values follow the real ones until force is taken.
				if (!force_active) begin
					frc_start_q[s] <= real_start;
					frc_trip_q[s] <= real_trip;
				end else if (w_s && wa_off == 9'(`IXS_STG_STATUS)) begin
					frc_start_q[s] <= hwdata[`IXS_ST_START]; // R04
					frc_trip_q[s] <= hwdata[`IXS_ST_TRIP]; // R04
				end
			end
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				stage_start[s] <= 1'b0;
				stage_trip[s] <= 1'b0;
				scnt_q[s] <= 16'h0;
				tcnt_q[s] <= 16'h0;
			end else begin
				stage_start[s] <= nxt_start;
				stage_trip[s] <= nxt_trip;
				// A count edge in the clearing cycle survives as one.
				scnt_q[s] <= ((w_s && wa_off == 9'(`IXS_STG_CNT) && hwdata[`IXS_CNT_CLR_START])
					? 16'h0 : scnt_q[s]) + 16'(nxt_start && !stage_start[s]); // R06 R25
				tcnt_q[s] <= ((w_s && wa_off == 9'(`IXS_STG_CNT) && hwdata[`IXS_CNT_CLR_TRIP])
					? 16'h0 : tcnt_q[s]) + 16'(nxt_trip && !stage_trip[s]); // R06 R25
			end
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				el_q[s] <= 32'h0;
				rl_q[s] <= 32'h0;
				acc_q[s] <= 32'h0;
				pct_q[s] <= 7'h0;
			end else if (fault_end) begin
				el_q[s] <= 32'h0; // R24
				rl_q[s] <= 32'h0;
				acc_q[s] <= 32'h0;
				pct_q[s] <= 7'h0;
			end else begin
				if (tick_q && pk[s]) begin
					el_q[s] <= (el_q[s] == `IXS_INF) ? el_q[s] : el_q[s] + 32'h1; // R21
					rl_q[s] <= 32'h0;
				end else if (tick_q && in_fault) begin
					rl_q[s] <= rl_q[s] + 32'h1; // R21 R24
				end
				// Percent grows by one step per cycle, at most a hundred steps per tick; a zero delay sets a hundred at once.
				if (dly == 32'h0 && in_fault) begin
					pct_q[s] <= `IXS_PCT_FULL; // R13
				end else if (acc_n >= dly && pct_q[s] < `IXS_PCT_FULL && dly != 32'h0) begin
					acc_q[s] <= acc_n - dly;
					pct_q[s] <= pct_q[s] + 7'h1; // R13
				end else begin
					acc_q[s] <= acc_n;
				end
			end
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				in_fault_q <= 1'b0;
				minv_q[s] <= 32'h0;
				tsd_q[s] <= 32'h0;
				tst_q[s] <= 32'h0;
				wp_q[s] <= 3'h0;
			end else begin
				in_fault_q <= pk[s] || (el_q[s] != 32'h0);
				if (fault_beg) begin
					tsd_q[s] <= rtc_date; // R12
					tst_q[s] <= rtc_ms_of_day; // R12
					minv_q[s] <= qty;
				end else if (pk[s] && smaller) begin
					minv_q[s] <= qty; // R11
				end
				if (fault_end)
					wp_q[s] <= wp_q[s] + 3'h1; // R11
			end
		end

		// Record memory is plain storage and needs no reset.
		always_ff @(posedge hclk) begin
			if (fault_end) begin
				rec_date[s][wp_q[s]] <= tsd_q[s]; // R11
				rec_time[s][wp_q[s]] <= tst_q[s];
				rec_qty[s][wp_q[s]] <= minv_q[s];
				rec_info[s][wp_q[s]] <= {22'h0, grp[s], 1'b0, pct_q[s]};
			end
		end
	end

	// Read decode; record 0 is the newest fault.
	wire [1:0] rs = 2'(wa_blk - 3'h1);
	wire [2:0] rr = 3'(wp_q[rs] - 3'h1 - addr_q[6:4]);
	wire [1:0] rg = addr_q[5:4];
	wire [31:0] r_dly = dly_q[rs][grp[rs]];
	wire [31:0] r_ttt = !pk[rs] ? `IXS_INF : (el_q[rs] >= r_dly) ? 32'h0 : r_dly - el_q[rs];
	wire [31:0] r_ohm = 32'(set_a_q[rs][grp[rs]][15:0]) * 32'(zn_q);

	always_comb begin
		rd_mux = 32'h0;
		if (wa_blk == 3'h0) begin
			unique case (wa_off)
				`IXS_REG_CTRL: rd_mux = {31'h0, force_active};
				`IXS_REG_ZN: rd_mux = {16'h0, zn_q};
				`IXS_REG_RATEDP: rd_mux = ratedp_q;
				`IXS_REG_U1: rd_mux = {16'h0, u1_volts}; // R10
				`IXS_REG_I1: rd_mux = {16'h0, i1_amps}; // R10
				`IXS_REG_P: rd_mux = p_q;
				`IXS_REG_Q: rd_mux = q_q;
				`IXS_REG_ZOHM: rd_mux = z_mohm_q; // R08
				`IXS_REG_ZPU: rd_mux = z_mpu_q; // R08
				default: rd_mux = 32'h0;
			endcase
		end else if (wa_blk <= 3'h3) begin
			if (wa_off[8]) begin
				unique case (addr_q[3:2])
					2'h0: rd_mux = rec_date[rs][rr]; // R11
					2'h1: rd_mux = rec_time[rs][rr];
					2'h2: rd_mux = rec_qty[rs][rr];
					2'h3: rd_mux = rec_info[rs][rr];
				endcase
			end else if (wa_off[6]) begin
				unique case (addr_q[3:2])
					2'h0: rd_mux = set_a_q[rs][rg];
					2'h1: rd_mux = set_b_q[rs][rg];
					2'h2: rd_mux = dly_q[rs][rg];
					2'h3: rd_mux = rel_q[rs][rg];
				endcase
			end else if (!wa_off[7]) begin
				unique case (wa_off[5:0])
					`IXS_STG_STATUS: rd_mux = {29'h0, stage_trip[rs], stage_start[rs],
						stage_block[rs]}; // R04
					`IXS_STG_CFG: rd_mux = {22'h0, cfg_q[rs]};
					`IXS_STG_ACTIVE: rd_mux = {30'h0, grp[rs]};
					`IXS_STG_CNT: rd_mux = {tcnt_q[rs], scnt_q[rs]};
					`IXS_STG_TTT: rd_mux = r_ttt; // R07
					`IXS_STG_PCT: rd_mux = {25'h0, pct_q[rs]};
					`IXS_STG_PICKOHM: rd_mux = r_ohm; // R09
					default: rd_mux = 32'h0;
				endcase
			end
		end
	end

endmodule : ixs_stages

// ### verif/ixs_stages_assertions.sv
/*
 Checker of the stage block: bus answer timing, force timeout, stage outputs.
 Assumes the one slave's hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
module ixs_chk #(
	parameter int unsigned TICK_CYCLES = 50000,
	parameter int unsigned FORCE_MS = 300000
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [15:0] i1_amps,
	input wire logic [2:0] stage_block,
	input wire logic [2:0] stage_start,
	input wire logic [2:0] stage_trip,
	input wire logic force_active
);
	// Slack covers the tick phase at set time and the write's data phase.
	localparam longint LIM = longint'(FORCE_MS) * TICK_CYCLES + 2 * TICK_CYCLES + 8;
	logic [39:0] fcnt_q;
	logic [39:0] fcnt_d;
	wire taken = hsel && hready && htrans[1];
	wire rd_req = taken && !hwrite;
	wire ctrl_wr = taken && hwrite && (haddr[11:0] == 12'h000);
	assign fcnt_d = (!force_active || ctrl_wr) ? 40'h0 : fcnt_q + 40'h1;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) fcnt_q <= 40'h0;
		else fcnt_q <= fcnt_d;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence rd_taken;
		rd_req;
	endsequence
	sequence rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence
	okay_resp_a: assert property (hresp == 1'b0)
		else $error("error response seen");
	read_wait_a: assert property (rd_taken |=> rd_answer)
		else $error("read answer not after one wait cycle");
	write_nowait_a: assert property (taken && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	wait_cause_a: assert property ($fell(hreadyout) |-> $past(rd_req))
		else $error("wait state without a read");
	reset_quiet_a: assert property ($rose(hresetn) |->
		hreadyout && !force_active && stage_start == 3'h0 && stage_trip == 3'h0)
		else $error("outputs not idle out of reset");
	force_bound_a: assert property (fcnt_q <= LIM)
		else $error("force flag outlived its timeout");
	trip_start_a: assert property (!force_active && !$past(force_active) |->
		(stage_trip & ~$past(stage_trip) & ~stage_start) == 3'h0)
		else $error("trip rose without start");
	blocked_quiet_a: assert property (!force_active && !$past(force_active) |->
		(stage_start & ~$past(stage_start) & $past(stage_block)) == 3'h0)
		else $error("blocked stage started");
	standstill_a: assert property (!force_active && !$past(force_active) &&
		(stage_start & ~$past(stage_start) & 3'h3) != 3'h0 |-> $past(i1_amps) != 16'h0)
		else $error("impedance stage started at zero current");
endmodule : ixs_chk

bind ixs_stages ixs_chk #(.TICK_CYCLES(TICK_CYCLES), .FORCE_MS(FORCE_MS)) u_chk (.hclk,
	.hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .i1_amps,
	.stage_block, .stage_start, .stage_trip, .force_active);

// ### verif/ixs_meas_model.sv
/*
 Measurement front end: magnitudes, fundamental phasors and a time stamp.
 Assumes mode is set by the bench; outputs follow mode at once.
*/
`timescale 1ns/1ps
module ixs_meas_model #(
	parameter int unsigned HALF = 30,
	parameter logic [31:0] DATE = 32'h00010203
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [2:0] mode,
	output logic [15:0] u1_volts,
	output logic [15:0] i1_amps,
	output logic signed [15:0] u12_re,
	output logic signed [15:0] u12_im,
	output logic signed [15:0] u32_re,
	output logic signed [15:0] u32_im,
	output logic signed [15:0] ia_re,
	output logic signed [15:0] ia_im,
	output logic signed [15:0] ic_re,
	output logic signed [15:0] ic_im,
	output logic [31:0] rtc_date,
	output logic [31:0] rtc_ms_of_day
);
	// Swing halves span whole ticks so each capacitive spell is short of the delay.
	logic [7:0] ph_q;
	logic sw_q;
	logic [31:0] ms_q;
	wire flt = mode == 3'h1;
	wire stand = mode == 3'h2;
	wire cap = mode == 3'h3 || (mode == 3'h4 && sw_q);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_q <= 8'h00;
			sw_q <= 1'b0;
			ms_q <= 32'h00000000;
		end else begin
			ph_q <= (ph_q == 8'(HALF - 1)) ? 8'h00 : ph_q + 8'h01;
			sw_q <= (ph_q == 8'(HALF - 1)) ? ~sw_q : sw_q;
			ms_q <= ms_q + 32'h00000001;
		end
	end
	assign u1_volts = flt ? 16'h0001 : 16'h0064;
	assign i1_amps = stand ? 16'h0000 : (flt ? 16'h0064 : 16'h000A);
	assign u12_re = stand ? 16'sh0000 : 16'sh03E8;
	assign u12_im = 16'sh0000;
	assign u32_re = 16'sh0000;
	assign u32_im = 16'sh0000;
	assign ia_re = 16'sh0000;
	assign ia_im = stand ? 16'sh0000 : (cap ? 16'sh03E8 : -16'sh03E8);
	assign ic_re = 16'sh0000;
	assign ic_im = 16'sh0000;
	assign rtc_date = DATE;
	assign rtc_ms_of_day = ms_q;
endmodule : ixs_meas_model

// ### verif/impedance_excitation_stages_tb.sv
/*
 Bench of the stage block: bus tasks, impedance, force, group and excitation runs.
 Assumes short tick and force counts through the design's parameters.
*/
`timescale 1ns/1ps
module impedance_excitation_stages_tb;
	import ixs_pkg::*;
	localparam int unsigned TK = 10;
	localparam int unsigned FM = 5;
	localparam logic [31:0] DATE = 32'h00010203;
	logic hclk, hresetn, hsel, hwrite, hresp, hreadyout, force_active, hit;
	logic [31:0] haddr, hwdata, hrdata, rd, di, vi, led, vo, rtc_date, rtc_ms;
	logic [1:0] htrans;
	logic [2:0] hsize, blk, mode, stage_start, stage_trip;
	logic [15:0] u1, i1;
	logic signed [15:0] u12r, u12i, u32r, u32i, iar, iai, icr, ici;
	logic [1:0] gexp [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
	int miscompares, compares;
	wire hready = hreadyout;
	wire [6:0] obs = {force_active, stage_trip, stage_start};
	ixs_stages #(.TICK_CYCLES(TK), .FORCE_MS(FM)) dut (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
		.u1_volts(u1), .i1_amps(i1), .u12_re(u12r), .u12_im(u12i), .u32_re(u32r),
		.u32_im(u32i), .ia_re(iar), .ia_im(iai), .ic_re(icr), .ic_im(ici), .rtc_date,
		.rtc_ms_of_day(rtc_ms), .digital_input_n(di), .virtual_input_n(vi),
		.led_signal_n(led), .virtual_output_n(vo), .stage_block(blk), .stage_start,
		.stage_trip, .force_active);
	ixs_meas_model #(.HALF(3 * TK), .DATE(DATE)) u_meas (.hclk, .hresetn, .mode,
		.u1_volts(u1), .i1_amps(i1), .u12_re(u12r), .u12_im(u12i), .u32_re(u32r),
		.u32_im(u32i), .ia_re(iar), .ia_im(iai), .ic_re(icr), .ic_im(ici), .rtc_date,
		.rtc_ms_of_day(rtc_ms));
	task close_out;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Entered just after a rising edge; the request stands until hready is sampled high.
	task bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
		int n;
		n = 0;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 100);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 100);
		rd = hrdata;
		if (n >= 100) begin
			miscompares++;
			close_out;
		end
	endtask : bus
	task wr(input logic [31:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask : wr
	task rc(input logic [31:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(rd, e);
	endtask : rc
	task wait_for(input int b, input logic v, input int lim);
		int n;
		n = 0;
		while (obs[b] !== v) begin
			@(posedge hclk);
			n++;
			if (n > lim) begin
				miscompares++;
				close_out;
			end
		end
	endtask : wait_for
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	initial begin
		repeat (40000) @(posedge hclk);
		miscompares++;
		close_out;
	end
	initial begin
		{hresetn, hwrite, haddr, htrans, hwdata, blk, mode, hit} = '0;
		{hsel, hsize} = {1'b1, 3'h2};
		{di, vi, led, vo} = {32'h20, 32'h10, 32'h0F, 32'h30};
		{miscompares, compares} = '0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rc(32'h004, 32'h000003E8);
		rc(32'h008, 32'h00010000);
		rc(32'h240, 32'h000001F4);
		rc(32'h218, 32'h0007A120);
		rc(32'h210, 32'hFFFFFFFF);
		rc(32'hFFC, 32'h00000000);
		wr(32'h248, 32'h00000003);
		blk <= 3'h2;
		mode <= 3'h1;
		wait_for(0, 1'b1, 100);
		wait_for(3, 1'b1, 100);
		repeat (100) @(posedge hclk);
		rc(32'h210, 32'h00000000);
		rc(32'h00C, 32'h00000001);
		rc(32'h010, 32'h00000064);
		rc(32'h01C, 32'h0000000A);
		rc(32'h020, 32'h0000000A);
		chk({31'h0, stage_start[1]}, 32'h0);
		rc(32'h20C, 32'h00010001);
		mode <= 3'h2;
		blk <= 3'h0;
		wait_for(0, 1'b0, 100);
		repeat (100) @(posedge hclk);
		rc(32'h01C, 32'hFFFFFFFF);
		rc(32'h300, DATE);
		rc(32'h308, 32'h0000000A);
		rc(32'h30C, 32'h00000064);
		wr(32'h20C, 32'h1);
		rc(32'h20C, 32'h00010000);
		wr(32'h20C, 32'h2);
		rc(32'h20C, 32'h00000000);
		wr(32'h200, 32'h6);
		rc(32'h200, 32'h00000000);
		wr(32'h000, 32'h1);
		rc(32'h000, 32'h00000001);
		wr(32'h200, 32'h6);
		rc(32'h200, 32'h00000006);
		chk({30'h0, stage_trip[0], stage_start[0]}, 32'h3);
		wait_for(6, 1'b0, FM * TK + 60);
		repeat (2) @(posedge hclk);
		rc(32'h200, 32'h00000000);
		for (int k = 0; k < 5; k++) begin
			wr(32'h204, {22'h0, 5'h4, 3'(k), 2'h3});
			rc(32'h208, {30'h0, gexp[k]});
		end
		wr(32'h204, 32'h0);
		wr(32'h640, 32'hFFFFFF9C);
		wr(32'h644, 32'hFFFFFF9C);
		wr(32'h648, 32'h00000005);
		mode <= 3'h3;
		wait_for(5, 1'b1, 150);
		rc(32'h018, 32'hFFFC2F70);
		rc(32'h014, 32'h00000000);
		mode <= 3'h0;
		wait_for(2, 1'b0, 100);
		// Let two ticks pass so the earlier fault closes before the swing starts.
		repeat (2 * TK) @(posedge hclk);
		mode <= 3'h4;
		repeat (300) begin
			@(posedge hclk);
			hit = hit | (stage_trip[2] === 1'b1);
		end
		chk({31'h0, hit}, 32'h0);
		mode <= 3'h0;
		wait_for(2, 1'b0, 100);
		wr(32'h64C, 32'h00000014);
		mode <= 3'h4;
		wait_for(5, 1'b1, 400);
		close_out;
	end
endmodule : impedance_excitation_stages_tb
